/* File: rtl/addr_strap_decoder.sv */
// decodes the two resistor select codes into the 6-bit bus address
`timescale 1ns/1ns
module addr_strap_decoder (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // resistor codes from the select pins, kilohm scale
  input wire logic [7:0] i_high_octal_select_pin_code,
  input wire logic [7:0] i_low_octal_select_pin_code,
  // decoded address
  output logic [5:0] o_address
);
  logic [7:0] high_s1;
  logic [7:0] high_s2;
  logic [7:0] low_s1;
  logic [7:0] low_s2;
  logic captured;

  function automatic logic [2:0] decode_digit(input logic [7:0] code);
    logic [2:0] d;
    d = 3'h0;
    for (int i = 0; i < 7; i++)
      if (code >= pmbus_target_pkg::DIGIT_EDGE[i])
        d = 3'(i + 1);
    return d;
  endfunction

  // codes come from pins; two stages before use
  always_ff @(posedge i_clk_sys)
  begin
    high_s1 <= i_high_octal_select_pin_code;
    high_s2 <= high_s1;
    low_s1 <= i_low_octal_select_pin_code;
    low_s2 <= low_s1;
  end

  // strap caught once after reset release; the address must not move mid-transaction
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      captured <= 1'b0;
      o_address <= 6'h00;
    end
    else if (!captured)
    begin
      captured <= 1'b1;
      o_address <= {decode_digit(high_s2), decode_digit(low_s2)};
    end
  end
endmodule

/* File: rtl/pmbus_target.sv */
// pmbus target: byte engine, packet check, settings, alert and alert-response addressing
`timescale 1ns/1ns
module pmbus_target #(
  parameter int STRETCH_LIMIT_CYCLES = pmbus_target_pkg::STRETCH_MAX_CYCLES
) (
  // system clock and reset
  input wire logic i_clk_sys,
  input wire logic i_reset,
  // serial bus, clock pin also clocks the link shifter
  input wire logic i_scl,
  output logic o_scl_out,
  output logic o_scl_oe,
  input wire logic i_sda_in,
  output logic o_sda_out,
  output logic o_sda_oe,
  // alert line, open drain
  output logic o_alert_out,
  output logic o_alert_oe,
  // address select codes and power stage fault level
  input wire logic [7:0] i_high_octal_select_pin_code,
  input wire logic [7:0] i_low_octal_select_pin_code,
  input wire logic i_fault,
  // settings toward the power stage
  output logic [15:0] o_vout_command,
  output logic [15:0] o_vin_on
);
  typedef enum logic [2:0] {st_idle, st_rx, st_ack_wait, st_ack, st_tx, st_tx_ack, st_tx_load} state_t;

  state_t state;
  logic [7:0] link_shift;
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d, fault_s1, fault_s2;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  logic [2:0] bit_cnt, byte_idx, tx_idx;
  logic rd_mode, is_ara, in_xfer, addr_phase;
  logic [7:0] rx_buf [0:3];
  logic [7:0] crc, crc_prev, tx_byte, tx_first, tx_next;
  logic [5:0] own_addr;
  logic own_hit, ara_hit, ara_mode, alerting, ara_done;
  logic [1:0] status;
  pmbus_target_pkg::settings_t work, nv;
  logic [7:0] cmd;
  logic [2:0] n_data;
  logic [3:0] exp_len;
  logic [15:0] wr_word;
  logic write_end, pec_present, pec_ok, pec_bad, bad_exp, exec, clear_any, load_first;
  logic [pmbus_target_pkg::STRETCH_CNT_W-1:0] stretch_cnt, hold_len;
  logic pin_level;

  addr_strap_decoder u_addr (
    .i_clk_sys(i_clk_sys),
    .i_reset(i_reset),
    .i_high_octal_select_pin_code(i_high_octal_select_pin_code),
    .i_low_octal_select_pin_code(i_low_octal_select_pin_code),
    .o_address(own_addr)
  );

  // link domain: data is stable around the rising clock edge, so sample there
  always_ff @(posedge i_scl)
  begin
    link_shift <= {link_shift[6:0], i_sda_in};
  end

  // oversampled pins, far faster than 400kHz
  always_ff @(posedge i_clk_sys)
  begin
    scl_s1 <= i_scl;
    scl_s2 <= scl_s1;
    scl_d <= scl_s2;
    sda_s1 <= i_sda_in;
    sda_s2 <= sda_s1;
    sda_d <= sda_s2;
    fault_s1 <= i_fault;
    fault_s2 <= fault_s1;
  end

  // bus events; link_shift is read only after the synchronised rise, when it is settled
  assign scl_rise = scl_s2 & ~scl_d;
  assign scl_fall = ~scl_s2 & scl_d;
  assign bus_start = scl_s2 & scl_d & sda_d & ~sda_s2;
  assign bus_stop = scl_s2 & scl_d & ~sda_d & sda_s2;

  // address matching
  assign ara_mode = work.alert_cfg[pmbus_target_pkg::ARA_MODE_BIT];
  assign alerting = |status;
  assign own_hit = (link_shift[7:1] == {1'b0, own_addr}) && !(ara_mode && alerting);
  assign ara_hit = (link_shift[7:1] == pmbus_target_pkg::ARA_ADDR) && ara_mode && alerting;

  function automatic logic [3:0] write_len(input logic [7:0] c);
    unique case (c)
      pmbus_target_pkg::CMD_CLEAR_FAULTS, pmbus_target_pkg::CMD_STORE_DEFAULT_ALL: return 4'h0;
      pmbus_target_pkg::CMD_ALERT_RESPONSE_CONFIG: return 4'h1;
      pmbus_target_pkg::CMD_VOUT_COMMAND, pmbus_target_pkg::CMD_VIN_ON: return 4'h2;
      default: return pmbus_target_pkg::LEN_NONE;
    endcase
  endfunction

  // data bytes, then the check byte
  function automatic logic [7:0] pick_tx(input logic [2:0] idx);
    logic [15:0] word;
    logic [2:0] len;
    word = 16'h0000;
    len = 3'h1;
    if (is_ara)
      word = {8'h00, 1'b0, own_addr, 1'b0};
    else
      unique case (rx_buf[0])
        pmbus_target_pkg::CMD_STATUS_BYTE: word = {14'h0000, status};
        pmbus_target_pkg::CMD_VOUT_MODE: word = {8'h00, pmbus_target_pkg::VOUT_MODE_VALUE};
        pmbus_target_pkg::CMD_ALERT_RESPONSE_CONFIG: word = {8'h00, work.alert_cfg};
        pmbus_target_pkg::CMD_VOUT_COMMAND:
        begin
          word = work.vout;
          len = 3'h2;
        end
        pmbus_target_pkg::CMD_VIN_ON:
        begin
          word = work.vin_on;
          len = 3'h2;
        end
        default: len = 3'h0;
      endcase
    if (idx < len)
      return (idx == 3'h0) ? word[7:0] : word[15:8];
    else if (idx == len)
      return crc;
    return pmbus_target_pkg::TX_IDLE_BYTE;
  endfunction

  // response bytes; a process, so that changes in settings, status and code are seen, not only the index
  always_comb
  begin
    tx_first = pick_tx(3'h0);
    tx_next = pick_tx(tx_idx + 3'h1);
  end
  assign load_first = (state == st_ack) && scl_fall && rd_mode;
  // modified receive byte ends at the master's acknowledge slot
  assign ara_done = (state == st_tx_ack) && scl_rise && is_ara && (tx_idx == 3'h0);

  // write decode at the stop condition
  always_comb
  begin
    cmd = rx_buf[0];
    n_data = byte_idx - 3'h1;
    exp_len = write_len(cmd);
    wr_word = {rx_buf[2], rx_buf[1]};
    write_end = bus_stop && in_xfer && !rd_mode && !is_ara && (byte_idx != 3'h0);
    pec_present = ({1'b0, n_data} == exp_len + 4'h1);
    pec_ok = (rx_buf[2'(byte_idx - 3'h1)] == crc_prev);
    pec_bad = write_end && pec_present && !pec_ok;
    // exponent must match the fixed one
    bad_exp = (cmd == pmbus_target_pkg::CMD_VIN_ON) &&
              (wr_word[pmbus_target_pkg::EXP_MSB:pmbus_target_pkg::EXP_LSB] != pmbus_target_pkg::VIN_ON_EXP);
    exec = write_end && (({1'b0, n_data} == exp_len) || (pec_present && pec_ok)) && !bad_exp;
    clear_any = (exec && (cmd == pmbus_target_pkg::CMD_CLEAR_FAULTS)) || ara_done;
  end

  // byte engine; start and stop override any state
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      state <= st_idle;
      bit_cnt <= 3'h0;
      byte_idx <= 3'h0;
      tx_idx <= 3'h0;
      rd_mode <= 1'b0;
      is_ara <= 1'b0;
      in_xfer <= 1'b0;
      addr_phase <= 1'b0;
      crc <= 8'h00;
      crc_prev <= 8'h00;
      tx_byte <= pmbus_target_pkg::TX_IDLE_BYTE;
      o_sda_oe <= 1'b0;
    end
    else if (bus_stop)
    begin
      state <= st_idle;
      in_xfer <= 1'b0;
      rd_mode <= 1'b0;
      is_ara <= 1'b0;
      o_sda_oe <= 1'b0;
    end
    else if (bus_start)
    begin
      state <= st_rx;
      bit_cnt <= 3'h0;
      addr_phase <= 1'b1;
      o_sda_oe <= 1'b0;
      if (!in_xfer)
      begin
        crc <= 8'h00;
        byte_idx <= 3'h0;
      end
    end
    else
    begin
      unique case (state)
        st_idle:
        begin
        end
        st_rx:
          if (scl_rise)
          begin
            bit_cnt <= bit_cnt + 3'h1;
            if (bit_cnt == 3'h7)
            begin
              crc_prev <= crc;
              crc <= pmbus_target_pkg::crc8_step(crc, link_shift);
              state <= st_ack_wait;
              if (addr_phase)
              begin
                addr_phase <= 1'b0;
                rd_mode <= link_shift[0];
                is_ara <= ara_hit;
                in_xfer <= own_hit || ara_hit;
                if (!(own_hit || ara_hit))
                  state <= st_idle;
              end
              else
              begin
                if (byte_idx < pmbus_target_pkg::RX_DEPTH)
                  rx_buf[byte_idx[1:0]] <= link_shift;
                if (byte_idx <= pmbus_target_pkg::RX_DEPTH)
                  byte_idx <= byte_idx + 3'h1;
              end
            end
          end
        st_ack_wait:
          if (scl_fall)
          begin
            o_sda_oe <= 1'b1;
            state <= st_ack;
          end
        st_ack:
          if (scl_fall)
          begin
            bit_cnt <= 3'h0;
            if (rd_mode)
            begin
              tx_idx <= 3'h0;
              tx_byte <= tx_first;
              crc <= pmbus_target_pkg::crc8_step(crc, tx_first);
              o_sda_oe <= ~tx_first[7];
              state <= st_tx;
            end
            else
            begin
              o_sda_oe <= 1'b0;
              state <= st_rx;
            end
          end
        st_tx:
          if (scl_fall)
          begin
            if (bit_cnt == 3'h7)
            begin
              o_sda_oe <= 1'b0;
              bit_cnt <= 3'h0;
              state <= st_tx_ack;
            end
            else
            begin
              tx_byte <= {tx_byte[6:0], 1'b1};
              o_sda_oe <= ~tx_byte[6];
              bit_cnt <= bit_cnt + 3'h1;
            end
          end
        st_tx_ack:
          if (scl_rise)
          begin
            if (!sda_s2)
            begin
              if (tx_idx != 3'h7)
                tx_idx <= tx_idx + 3'h1;
              tx_byte <= tx_next;
              crc <= pmbus_target_pkg::crc8_step(crc, tx_next);
              state <= st_tx_load;
            end
            else
              state <= st_idle;
          end
        st_tx_load:
          if (scl_fall)
          begin
            o_sda_oe <= ~tx_byte[7];
            state <= st_tx;
          end
      endcase
    end
  end

  // stretch while the response is staged, capped one cycle below the limit
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      stretch_cnt <= '0;
      hold_len <= '0;
      o_scl_oe <= 1'b0;
    end
    else
    begin
      if (load_first)
        stretch_cnt <= (pmbus_target_pkg::STRETCH_CYCLES < STRETCH_LIMIT_CYCLES) ?
                       pmbus_target_pkg::STRETCH_CNT_W'(pmbus_target_pkg::STRETCH_CYCLES) :
                       pmbus_target_pkg::STRETCH_CNT_W'(STRETCH_LIMIT_CYCLES - 1);
      else if (stretch_cnt != '0)
        stretch_cnt <= stretch_cnt - 1'b1;
      o_scl_oe <= load_first || (stretch_cnt > 1);
      hold_len <= o_scl_oe ? hold_len + 1'b1 : '0;
    end
  end

  // working settings and committed copy
  // reset reloads both from the factory values; a real part would keep nv
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      work <= pmbus_target_pkg::SETTINGS_DEFAULT;
      nv <= pmbus_target_pkg::SETTINGS_DEFAULT;
    end
    else if (exec)
      unique case (cmd)
        pmbus_target_pkg::CMD_ALERT_RESPONSE_CONFIG: work.alert_cfg <= rx_buf[1];
        // unsigned mantissa, exponent fixed by mode byte
        pmbus_target_pkg::CMD_VOUT_COMMAND: work.vout <= wr_word;
        pmbus_target_pkg::CMD_VIN_ON: work.vin_on <= wr_word;
        pmbus_target_pkg::CMD_STORE_DEFAULT_ALL: nv <= work;
        default:
        begin
        end
      endcase
  end

  assign o_vout_command = work.vout;
  assign o_vin_on = work.vin_on;

  // check failure raises the communication fault
  // clear releases; a new event in the same cycle wins
  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
      status <= 2'b00;
    else
    begin
      status[pmbus_target_pkg::STATUS_CML_BIT] <= pec_bad ||
                                                  (status[pmbus_target_pkg::STATUS_CML_BIT] && !clear_any);
      status[pmbus_target_pkg::STATUS_OTHER_BIT] <= fault_s2 ||
                                                    (status[pmbus_target_pkg::STATUS_OTHER_BIT] && !clear_any);
    end
  end

  always_ff @(posedge i_clk_sys)
  begin
    if (i_reset)
    begin
      o_alert_oe <= 1'b0;
      pin_level <= 1'b0;
    end
    else
    begin
      o_alert_oe <= alerting;
      pin_level <= 1'b0; // open drain: only ever drives low
    end
  end

  assign o_sda_out = pin_level;
  assign o_scl_out = pin_level;
  assign o_alert_out = pin_level;

  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  sequence s_ara_read;
    ara_done && !fault_s2;
  endsequence
  sequence s_alert_cleared;
    (status == 2'b00) ##1 !o_alert_oe;
  endsequence

  property p_stretch_bounded;
    o_scl_oe |-> (hold_len < STRETCH_LIMIT_CYCLES);
  endproperty
  a_stretch_bounded: assert property (p_stretch_bounded) else $error("clock held low too long");
  property p_pec_discard;
    pec_bad |-> !exec ##1 (status[pmbus_target_pkg::STATUS_CML_BIT] && $stable(work));
  endproperty
  a_pec_discard: assert property (p_pec_discard) else $error("bad check byte not discarded");
  property p_no_pec_exec;
    (write_end && ({1'b0, n_data} == exp_len) && !bad_exp) |-> exec;
  endproperty
  a_no_pec_exec: assert property (p_no_pec_exec) else $error("write without check byte dropped");
  property p_vin_exp;
    work.vin_on[pmbus_target_pkg::EXP_MSB:pmbus_target_pkg::EXP_LSB] == pmbus_target_pkg::VIN_ON_EXP;
  endproperty
  a_vin_exp: assert property (p_vin_exp) else $error("exponent changed");
  property p_store;
    (exec && cmd == pmbus_target_pkg::CMD_STORE_DEFAULT_ALL) |=> (nv == $past(work));
  endproperty
  a_store: assert property (p_store) else $error("store did not commit settings");
  property p_nv_volatile;
    !(exec && cmd == pmbus_target_pkg::CMD_STORE_DEFAULT_ALL) |=> $stable(nv);
  endproperty
  a_nv_volatile: assert property (p_nv_volatile) else $error("committed copy changed without store");
  property p_alert_on;
    alerting |=> o_alert_oe;
  endproperty
  a_alert_on: assert property (p_alert_on) else $error("alert not driven");
  property p_single_addr;
    !(own_hit && ara_hit);
  endproperty
  a_single_addr: assert property (p_single_addr) else $error("two addresses answered");
  property p_default_no_ara;
    !ara_mode |-> !ara_hit;
  endproperty
  a_default_no_ara: assert property (p_default_no_ara) else $error("response address answered in default mode");
  property p_clear;
    (exec && cmd == pmbus_target_pkg::CMD_CLEAR_FAULTS && !fault_s2) |=> s_alert_cleared;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not release alert");
  property p_ara_hides_own;
    (ara_mode && alerting) |-> !own_hit;
  endproperty
  a_ara_hides_own: assert property (p_ara_hides_own) else $error("own address answered while alerting");
  property p_ara_only_alerting;
    ara_hit |-> alerting;
  endproperty
  a_ara_only_alerting: assert property (p_ara_only_alerting) else $error("idle device took response address");
  property p_ara_release;
    s_ara_read |=> s_alert_cleared;
  endproperty
  a_ara_release: assert property (p_ara_release) else $error("alert kept after address read");
endmodule

/* File: rtl/pmbus_target_pkg.sv */
// shared constants, settings type and crc helper for the pmbus target
package pmbus_target_pkg;
  // system clock rate and clock-stretch timing
  localparam int CLK_SYS_MHZ = 100;
  localparam int STRETCH_MAX_MS = 35;
  localparam int STRETCH_MAX_CYCLES = STRETCH_MAX_MS * 1000 * CLK_SYS_MHZ;
  localparam int STRETCH_TIME_NS = 1000;
  localparam int STRETCH_CYCLES = (STRETCH_TIME_NS * CLK_SYS_MHZ + 999) / 1000;
  localparam int STRETCH_CNT_W = 23;

  // bus addresses and command codes
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
  localparam logic [7:0] CMD_STORE_DEFAULT_ALL = 8'h11;
  localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
  localparam logic [7:0] CMD_VOUT_COMMAND = 8'h21;
  localparam logic [7:0] CMD_VIN_ON = 8'h35;
  localparam logic [7:0] CMD_STATUS_BYTE = 8'h78;
  localparam logic [7:0] CMD_ALERT_RESPONSE_CONFIG = 8'hE0;

  // field positions
  localparam int ARA_MODE_BIT = 4;
  localparam int STATUS_CML_BIT = 1;
  localparam int STATUS_OTHER_BIT = 0;
  localparam int EXP_MSB = 15;
  localparam int EXP_LSB = 11;

  // data format constants: vout exponent -12, vin_on exponent -3
  localparam logic [7:0] VOUT_MODE_VALUE = 8'h14;
  localparam logic [4:0] VIN_ON_EXP = 5'h1D;

  // reset values
  localparam logic [7:0] ALERT_CFG_DEFAULT = 8'h00;
  localparam logic [15:0] VOUT_DEFAULT = 16'hC000;
  localparam logic [15:0] VIN_ON_DEFAULT = 16'hE910;

  // byte engine constants
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] TX_IDLE_BYTE = 8'hFF;
  localparam logic [2:0] RX_DEPTH = 3'h4;
  localparam logic [3:0] LEN_NONE = 4'hE;

  // digit edges on the resistor code scale, at the geometric midpoints between nominal values
  localparam logic [7:0] DIGIT_EDGE [0:6] = '{8'h0C, 8'h13, 8'h1E, 8'h2D, 8'h44, 8'h69, 8'hA1};

  // settings that software writes and that can be committed
  typedef struct packed {
    logic [7:0] alert_cfg;
    logic [15:0] vout;
    logic [15:0] vin_on;
  } settings_t;

  localparam settings_t SETTINGS_DEFAULT = '{alert_cfg: ALERT_CFG_DEFAULT, vout: VOUT_DEFAULT,
                                             vin_on: VIN_ON_DEFAULT};

  // one byte step of the packet check code, msb first
  function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc ^ data;
    for (int i = 0; i < 8; i++)
      c = c[7] ? ((c << 1) ^ CRC_POLY) : (c << 1);
    return c;
  endfunction
endpackage

/* File: testbench/pmbus_master_model.sv */
// bus master model: open-drain pulls on the clock and data wires
`timescale 1ns/1ns
module pmbus_master_model (
  // link tick
  input wire logic i_tick,
  // resolved wire levels
  input wire logic i_scl,
  input wire logic i_sda,
  // pulls, high drags the wire low
  output logic o_scl_pull,
  output logic o_sda_pull
);
  // both wires left to the pull-ups until the first frame
  initial
  begin
    o_scl_pull = 1'b0;
    o_sda_pull = 1'b0;
  end
  // quarter bit of ten ticks, scl near 390kHz
  task automatic q();
    repeat (10) @(posedge i_tick);
  endtask
  task automatic bit_io(input logic b, output logic r);
    o_sda_pull <= ~b;
    q();
    o_scl_pull <= 1'b0;
    // waits out a stretch, the bench timeout bounds it
    wait (i_scl === 1'b1);
    q();
    r = i_sda;
    q();
    o_scl_pull <= 1'b1;
    q();
  endtask
  // start or repeated start: data falls while the clock is high
  task automatic start();
    o_sda_pull <= 1'b0;
    q();
    o_scl_pull <= 1'b0;
    q();
    o_sda_pull <= 1'b1;
    q();
    o_scl_pull <= 1'b1;
    q();
  endtask
  // stop: data rises while the clock is high, then both released
  task automatic stop();
    o_sda_pull <= 1'b1;
    q();
    o_scl_pull <= 1'b0;
    q();
    o_sda_pull <= 1'b0;
    q();
  endtask
  // one byte msb first, then the acknowledge bit
  task automatic xbyte(input logic [7:0] w, input logic ma, output logic [7:0] r, output logic sa);
    for (int i = 7; i >= 0; i--)
      bit_io(w[i], r[i]);
    bit_io(ma, sa);
  endtask
endmodule

/* File: testbench/testbench.sv */
// testbench for the pmbus target driven by the master model
`timescale 1ns/1ns
module testbench;
  localparam int LIMIT = 100000;
  logic clk, tick, rst, flt, sp, dp, a, scl_oe, sda_oe, al_oe, so, dout, aout;
  logic [7:0] hc, lc, pc, rb;
  logic [5:0] adr;
  logic [15:0] vout, vin, v, got, e;
  logic [15:0] exp_q[$];
  logic [7:0] code [0:7] = '{8'h0A, 8'h0F, 8'h18, 8'h25, 8'h37, 8'h55, 8'h82, 8'hC8};
  int n_fail, checks_done, cyc;
  event ev;
  // open-drain wires with pull-ups
  wire scl = ~(sp | scl_oe);
  wire sda = ~(dp | sda_oe);
  pmbus_target #(.STRETCH_LIMIT_CYCLES(200)) i_dut (
    .i_clk_sys(clk), .i_reset(rst), .i_scl(scl), .o_scl_out(so), .o_scl_oe(scl_oe),
    .i_sda_in(sda), .o_sda_out(dout), .o_sda_oe(sda_oe), .o_alert_out(aout), .o_alert_oe(al_oe),
    .i_high_octal_select_pin_code(hc), .i_low_octal_select_pin_code(lc), .i_fault(flt),
    .o_vout_command(vout), .o_vin_on(vin));
  pmbus_master_model i_m (.i_tick(tick), .i_scl(scl), .i_sda(sda), .o_scl_pull(sp), .o_sda_pull(dp));
  // system clock and a link tick of unrelated phase
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial
  begin
    tick = 1'b0;
    #17;
    forever #32 tick = ~tick;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard, sized above the longest expected run
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      n_fail++;
      end_of_test();
    end
  end
  // note the expectation, hand the result to the watcher
  task automatic chk(input logic [15:0] x, input logic [15:0] y);
    exp_q.push_back(x);
    got = y;
    -> ev;
    #20;
  endtask
  // watcher pairs each result with the oldest note
  always @(ev)
  begin
    e = exp_q.pop_front();
    checks_done++;
    if (got !== e)
    begin
      n_fail++;
      $display("[FAIL] %0t exp %h got %h", $time, e, got);
    end
  end
  // own check code model, kept apart from the design's helper
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] d);
    c = c ^ d;
    for (int i = 0; i < 8; i++)
      c = c[7] ? ((c << 1) ^ 8'h07) : (c << 1);
    return c;
  endfunction
  task automatic send(input logic [7:0] b);
    i_m.xbyte(b, 1'b1, rb, a);
    pc = crc(pc, b);
  endtask
  // address probe: start, one byte, stop
  task automatic hit(input logic [7:0] b, input logic x);
    i_m.start();
    send(b);
    chk(16'(x), 16'(a));
    i_m.stop();
  endtask
  // write; pec 0 none, 1 good, 2 corrupted
  task automatic wr(input logic [7:0] cmd, input logic [15:0] d, input int n, input int pec);
    pc = 8'h00;
    i_m.start();
    send({1'b0, adr, 1'b0});
    chk(16'h0, 16'(a));
    send(cmd);
    for (int k = 0; k < n; k++)
      send(d[8*k+:8]);
    if (pec != 0)
      send(pc ^ 8'(pec - 1));
    i_m.stop();
  endtask
  // read n bytes then the check byte; ara skips the command phase
  task automatic rd(input logic [7:0] cmd, input int n, input logic [15:0] x, input logic ara);
    pc = 8'h00;
    i_m.start();
    if (!ara)
    begin
      send({1'b0, adr, 1'b0});
      send(cmd);
      i_m.start();
      send({1'b0, adr, 1'b1});
    end
    else
      send(8'h19);
    chk(16'h0, 16'(a));
    for (int k = 0; k < n; k++)
    begin
      i_m.xbyte(8'hFF, 1'b0, rb, a);
      chk({8'h00, x[8*k+:8]}, {8'h00, rb});
      pc = crc(pc, x[8*k+:8]);
    end
    i_m.xbyte(8'hFF, 1'b1, rb, a);
    chk({8'h00, pc}, {8'h00, rb});
    i_m.stop();
  endtask
  // main sequence
  initial
  begin
    void'($urandom(32982));
    rst = 1'b1;
    flt = 1'b0;
    // high digit 2 or 3 stays clear of reserved addresses
    adr = {3'(2 + $urandom % 2), 3'($urandom % 8)};
    hc = code[adr[5:3]];
    lc = code[adr[2:0]];
    repeat (12) @(negedge clk);
    rst = 1'b0;
    repeat (10) @(negedge clk);
    v = 16'($urandom);
    wr(pmbus_target_pkg::CMD_VOUT_COMMAND, v, 2, 0);
    chk(v, vout);
    chk(16'h0, 16'(al_oe));
    rd(pmbus_target_pkg::CMD_VOUT_COMMAND, 2, v, 1'b0);
    wr(pmbus_target_pkg::CMD_VOUT_COMMAND, ~v, 2, 2);
    chk(v, vout);
    chk(16'h1, 16'(al_oe));
    // open-drain pins only ever drive low
    chk(16'h0, {13'h0000, so, dout, aout});
    hit(8'h19, 1'b1);
    rd(pmbus_target_pkg::CMD_STATUS_BYTE, 1, 16'h0002, 1'b0);
    wr(pmbus_target_pkg::CMD_CLEAR_FAULTS, 16'h0000, 0, 0);
    chk(16'h0, 16'(al_oe));
    wr(pmbus_target_pkg::CMD_VIN_ON, 16'hF100, 2, 0);
    chk(16'hE910, vin);
    // commit reaches the store and volatility assertions
    wr(pmbus_target_pkg::CMD_STORE_DEFAULT_ALL, 16'h0000, 0, 0);
    wr(pmbus_target_pkg::CMD_ALERT_RESPONSE_CONFIG, 16'h0010, 1, 1);
    flt = 1'b1;
    repeat (5) @(negedge clk);
    flt = 1'b0;
    repeat (5) @(negedge clk);
    chk(16'h1, 16'(al_oe));
    hit({1'b0, adr, 1'b0}, 1'b1);
    rd(8'h00, 1, {9'h000, adr, 1'b0}, 1'b1);
    chk(16'h0, 16'(al_oe));
    hit({1'b0, adr, 1'b0}, 1'b0);
    end_of_test();
  end
endmodule
